//--- rtl/sfb_settings.sv
/*
 Servo feedback settings: tuning selection, in-position detection,
 rotation sense and divided A/B encoder output, with an Avalon-MM
 register slave. Assumes position error and command steps come from
 logic on ref_clk; encoder step/direction arrive from pins.
*/
// Operation
// RQ1: Tune method register selects gain method, resets to 0001h.
// RQ2: Tune level accepts 1 to 32; other writes are ignored.
// RQ3: Each level maps to a rising guideline resonance, 10.0 to 400.0 Hz.
// RQ4: In-position output while error magnitude within window; window resets to 100.
// RQ5: Speed control mode disables in-position detection.
// RQ6: Sense 0: rising address turns counter-clockwise; sense 1 reverses.
// RQ7: Deferred settings take effect only after reset or driver reset.
// RQ8: Encoder setting is four times the A/B pulse count wanted.
// RQ9: Encoder setting accepts 1 to 65535, resets to 4000.
// RQ10: Controller keeps output rate at or below 4.6 Mpps after x4; the code has no limiter, up to one output edge per count.
// RQ11: Output mode digit 0: setting is edges per motor revolution.
// RQ12: Output mode digit 1: resolution 4194304 divided by setting, then four.
// RQ13: A/B outputs are quadrature, order following rotation.
`timescale 1ns/1ps
`include "sfb_params.svh"

module sfb_settings
	import sfb_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [31:0] pos_error,
	input  wire logic        cmd_step,
	input  wire logic        cmd_addr_up,
	input  wire logic        enc_step_pin,
	input  wire logic        enc_ccw_pin,
	output logic             in_position_output,
	output logic             motor_step_q,
	output logic             motor_ccw_q,
	output logic [15:0]      tune_method_selector,
	output logic [4:0]       tune_level_m1_q,
	output logic             enc_phase_a,
	output logic             enc_phase_b
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sfb_bus_t    bus_q;
	sfb_word_t   tune_method_q;
	sfb_word_t   tune_level_q;
	sfb_word_t   pos_window_q;
	sfb_word_t   rot_sense_q;
	sfb_word_t   pulse_out_q;
	sfb_word_t   out_mode_q;
	sfb_word_t   sense_act_q;
	sfb_word_t   pulse_act_q;
	sfb_word_t   mode_act_q;
	logic        speed_mode_q;
	logic        apply_q;
	logic        in_pos_q;
	logic [31:0] rdata_d;
	logic [31:0] err_mag;
	logic        err_in_win;
	logic        wr_en;
	logic [3:0]  widx;
	logic [11:0] res_freq;
	logic [2:0]  enc_step_sync_q;
	logic [1:0]  enc_ccw_sync_q;
	logic        enc_edge;
	logic [22:0] acc_q;
	logic [22:0] acc_sum;
	logic        quad_step_q;
	logic        quad_ccw_q;
	logic        div_mode;

	assign widx   = avs_address[5:2];
	assign wr_en  = avs_write && (bus_q == SFB_BUS_ACK);

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// Every access answers one cycle after the request; no back-to-back wait
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_q           <= SFB_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			case (bus_q)
				SFB_BUS_IDLE:
				begin
					if (avs_read || avs_write)
					begin
						bus_q           <= SFB_BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				SFB_BUS_ACK:
				begin
					bus_q           <= SFB_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default:
				begin
					bus_q           <= SFB_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	a_wait_pulse : assert property (@(posedge ref_clk) disable iff (rst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_req_answer : assert property (@(posedge ref_clk) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("request not answered within two cycles");

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (widx)
			`SFB_OFS_TUNE_METHOD: rdata_d = {16'h0000, tune_method_q};
			`SFB_OFS_TUNE_LEVEL:  rdata_d = {16'h0000, tune_level_q};
			`SFB_OFS_POS_WINDOW:  rdata_d = {16'h0000, pos_window_q};
			`SFB_OFS_ROT_SENSE:   rdata_d = {16'h0000, rot_sense_q};
			`SFB_OFS_PULSE_OUT:   rdata_d = {16'h0000, pulse_out_q};
			`SFB_OFS_OUT_MODE:    rdata_d = {16'h0000, out_mode_q};
			`SFB_OFS_CONTROL:     rdata_d = {31'h0000_0000, speed_mode_q};
			`SFB_OFS_STATUS:      rdata_d = {29'h0000_0000, div_mode,
				sense_act_q[0], in_pos_q};
			`SFB_OFS_RESONANCE:   rdata_d = {20'h0_0000, res_freq};
			`SFB_OFS_PULSE_ACT:   rdata_d = {16'h0000, pulse_act_q};
			default:              rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && bus_q == SFB_BUS_IDLE)
			avs_readdata <= rdata_d;
	end

	// ----------------------------------------
	// Immediate settings
	// ----------------------------------------
	// RQ1: tune method store
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			tune_method_q <= `SFB_RST_TUNE_METHOD;
		else if (wr_en && widx == `SFB_OFS_TUNE_METHOD)
			tune_method_q <= avs_writedata[15:0];
	end

	// RQ2: only 1 to 32 accepted
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			tune_level_q <= `SFB_RST_TUNE_LEVEL;
		else if (wr_en && widx == `SFB_OFS_TUNE_LEVEL
			&& avs_writedata[15:0] >= `SFB_LEVEL_MIN
			&& avs_writedata[15:0] <= `SFB_LEVEL_MAX
			&& avs_writedata[31:16] == 16'h0000)
			tune_level_q <= avs_writedata[15:0];
	end

	a_level_range : assert property (@(posedge ref_clk) disable iff (rst) // RQ2
		tune_level_q >= `SFB_LEVEL_MIN && tune_level_q <= `SFB_LEVEL_MAX)
		else $error("tune level outside 1 to 32");

	// RQ4: window store, full 16-bit range
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			pos_window_q <= `SFB_RST_POS_WINDOW;
		else if (wr_en && widx == `SFB_OFS_POS_WINDOW)
			pos_window_q <= avs_writedata[15:0];
	end

	// RQ5: speed mode flag
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			speed_mode_q <= 1'b0;
		else if (wr_en && widx == `SFB_OFS_CONTROL)
			speed_mode_q <= avs_writedata[`SFB_CTL_SPEED_BIT];
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tune_method_selector <= `SFB_RST_TUNE_METHOD;
			tune_level_m1_q      <= 5'h0B;
		end
		else
		begin
			tune_method_selector <= tune_method_q;
			tune_level_m1_q      <= 5'(tune_level_q - 16'h0001);
		end
	end

	// ----------------------------------------
	// Deferred settings
	// ----------------------------------------
	// Shadow copies take writes at once; the active copies only at apply
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rot_sense_q <= `SFB_RST_ROT_SENSE;
			pulse_out_q <= `SFB_RST_PULSE_OUT;
			out_mode_q  <= `SFB_RST_OUT_MODE;
		end
		else if (wr_en)
		begin
			if (widx == `SFB_OFS_ROT_SENSE && avs_writedata[31:1] == 31'h0)
				rot_sense_q <= avs_writedata[15:0];
			// RQ9: zero setting refused
			if (widx == `SFB_OFS_PULSE_OUT && avs_writedata[15:0] != 16'h0000)
				pulse_out_q <= avs_writedata[15:0];
			if (widx == `SFB_OFS_OUT_MODE)
				out_mode_q <= avs_writedata[15:0];
		end
	end

	// RQ7: apply after reset or driver reset
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			apply_q <= 1'b1;
		else
			apply_q <= wr_en && widx == `SFB_OFS_CONTROL
				&& avs_writedata[`SFB_CTL_DRST_BIT];
	end

	// RQ7: active copies load on apply only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sense_act_q <= `SFB_RST_ROT_SENSE;
			pulse_act_q <= `SFB_RST_PULSE_OUT;
			mode_act_q  <= `SFB_RST_OUT_MODE;
		end
		else if (apply_q)
		begin
			sense_act_q <= rot_sense_q;
			pulse_act_q <= pulse_out_q;
			mode_act_q  <= out_mode_q;
		end
	end

	a_defer_hold : assert property (@(posedge ref_clk) disable iff (rst) // RQ7
		!apply_q |=> $stable(sense_act_q) && $stable(pulse_act_q) && $stable(mode_act_q))
		else $error("deferred setting changed without apply");

	a_enc_nonzero : assert property (@(posedge ref_clk) disable iff (rst) // RQ9
		pulse_act_q != 16'h0000 && pulse_out_q != 16'h0000)
		else $error("encoder setting is zero");

	// ----------------------------------------
	// In-position detection
	// ----------------------------------------
	assign err_mag    = pos_error[31] ? 32'(~pos_error + 32'h0000_0001) : pos_error;
	assign err_in_win = err_mag <= {16'h0000, pos_window_q};

	// RQ4: window compare, RQ5: gated in speed mode
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			in_pos_q           <= 1'b0;
			in_position_output <= 1'b0;
		end
		else
		begin
			in_pos_q           <= err_in_win && !speed_mode_q;
			in_position_output <= err_in_win && !speed_mode_q;
		end
	end

	a_inpos_window : assert property (@(posedge ref_clk) disable iff (rst) // RQ4
		!rst && err_in_win && !speed_mode_q |=> in_position_output)
		else $error("in-position missing inside window");

	a_inpos_outside : assert property (@(posedge ref_clk) disable iff (rst) // RQ4
		!err_in_win |=> !in_position_output)
		else $error("in-position set outside window");

	a_inpos_speed : assert property (@(posedge ref_clk) disable iff (rst) // RQ5
		speed_mode_q |=> !in_position_output)
		else $error("in-position active in speed mode");

	// ----------------------------------------
	// Rotation sense
	// ----------------------------------------
	// RQ6: direction mapping through active sense
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			motor_step_q <= 1'b0;
			motor_ccw_q  <= 1'b0;
		end
		else
		begin
			motor_step_q <= cmd_step;
			if (cmd_step)
				motor_ccw_q <= cmd_addr_up ^ sense_act_q[0];
		end
	end

	a_dir_map : assert property (@(posedge ref_clk) disable iff (rst) // RQ6
		cmd_step |=> motor_step_q && (motor_ccw_q == $past(cmd_addr_up ^ sense_act_q[0])))
		else $error("motor direction does not follow sense");

	// ----------------------------------------
	// Encoder pin capture
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			enc_step_sync_q <= 3'h0;
			enc_ccw_sync_q  <= 2'h0;
		end
		else
		begin
			enc_step_sync_q <= {enc_step_sync_q[1:0], enc_step_pin};
			enc_ccw_sync_q  <= {enc_ccw_sync_q[0], enc_ccw_pin};
		end
	end

	assign enc_edge = enc_step_sync_q[1] && !enc_step_sync_q[2];

	// ----------------------------------------
	// Output pulse scaling
	// ----------------------------------------
	// Division mode counts motor counts per edge, avoiding a true divider
	assign div_mode = mode_act_q[`SFB_MODE_DIGIT_LSB +: 4] == `SFB_MODE_DIV;
	assign acc_sum  = acc_q + {7'h00, pulse_act_q};

	// RQ8: each output edge is a quarter pulse
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			acc_q       <= 23'h0;
			quad_step_q <= 1'b0;
			quad_ccw_q  <= 1'b0;
		end
		else
		begin
			quad_step_q <= 1'b0;
			if (apply_q)
				acc_q <= 23'h0;
			else if (enc_edge)
			begin
				quad_ccw_q <= enc_ccw_sync_q[1];
				if (div_mode)
				begin
					// RQ12: one edge per setting counts
					if (acc_q + 23'h1 >= {7'h00, pulse_act_q})
					begin
						acc_q       <= 23'h0;
						quad_step_q <= 1'b1;
					end
					else
						acc_q <= acc_q + 23'h1;
				end
				else
				begin
					// RQ11: setting edges per revolution
					if (acc_sum >= `SFB_ENC_RES)
					begin
						acc_q       <= acc_sum - `SFB_ENC_RES;
						quad_step_q <= 1'b1;
					end
					else
						acc_q <= acc_sum;
				end
			end
		end
	end

	a_div_edge : assert property (@(posedge ref_clk) disable iff (rst) // RQ12
		quad_step_q && $past(div_mode) |-> acc_q == 23'h0)
		else $error("division mode edge without counter wrap");

	a_acc_bound : assert property (@(posedge ref_clk) disable iff (rst) // RQ11
		!div_mode |-> acc_q < `SFB_ENC_RES)
		else $error("pulse accumulator above resolution");

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	sfb_quad_gen u_quad
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.step      (quad_step_q),
		.dir_ccw   (quad_ccw_q),
		.phase_a_q (enc_phase_a),
		.phase_b_q (enc_phase_b)
	);

	sfb_res_lut u_lut
	(
		.ref_clk  (ref_clk),
		.rst      (rst),
		.level_m1 (tune_level_m1_q),
		.freq_q   (res_freq)
	);

endmodule : sfb_settings

//--- rtl/sfb_params.svh
/*
 Offsets, reset values and limits of the servo feedback settings block.
 Assumes inclusion by bare name from rtl/ files and the bench.
*/
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

// ----------------------------------------
// Register word indexes (address bits 5:2)
// ----------------------------------------
`define SFB_OFS_TUNE_METHOD  4'h0
`define SFB_OFS_TUNE_LEVEL   4'h1
`define SFB_OFS_POS_WINDOW   4'h2
`define SFB_OFS_ROT_SENSE    4'h3
`define SFB_OFS_PULSE_OUT    4'h4
`define SFB_OFS_OUT_MODE     4'h5
`define SFB_OFS_CONTROL      4'h6
`define SFB_OFS_STATUS       4'h7
`define SFB_OFS_RESONANCE    4'h8
`define SFB_OFS_PULSE_ACT    4'h9

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SFB_RST_TUNE_METHOD  16'h0001
`define SFB_RST_TUNE_LEVEL   16'h000C
`define SFB_RST_POS_WINDOW   16'h0064
`define SFB_RST_ROT_SENSE    16'h0000
`define SFB_RST_PULSE_OUT    16'h0FA0
`define SFB_RST_OUT_MODE     16'h0000
`define SFB_LEVEL_MIN        16'h0001
`define SFB_LEVEL_MAX        16'h0020
`define SFB_ENC_RES          23'h400000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFB_CTL_SPEED_BIT    0
`define SFB_CTL_DRST_BIT     1
`define SFB_MODE_DIGIT_LSB   4
`define SFB_MODE_DIV         4'h1

`endif

//--- rtl/sfb_pkg.sv
/*
 Types shared by the servo feedback settings block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sfb_pkg;

	typedef logic [15:0] sfb_word_t;

	typedef enum logic [0:0]
	{
		SFB_BUS_IDLE = 1'b0,
		SFB_BUS_ACK  = 1'b1
	} sfb_bus_t;

endpackage : sfb_pkg

//--- rtl/sfb_quad_gen.sv
/*
 Quadrature A/B output stage: one gray step per request.
 Assumes step is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ps

module sfb_quad_gen
	import sfb_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic step,
	input  wire logic dir_ccw,
	output logic      phase_a_q,
	output logic      phase_b_q
);

	// ----------------------------------------
	// Gray sequence
	// ----------------------------------------
	// RQ13: quadrature order follows direction
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			phase_a_q <= 1'b0;
			phase_b_q <= 1'b0;
		end
		else if (step)
		begin
			if (dir_ccw ^ phase_a_q ^ phase_b_q)
				phase_a_q <= ~phase_a_q;
			else
				phase_b_q <= ~phase_b_q;
		end
	end

	a_quad_gray : assert property (@(posedge ref_clk) disable iff (rst) // RQ13
		step |=> ($countones({phase_a_q, phase_b_q} ^ $past({phase_a_q, phase_b_q})) == 1))
		else $error("quadrature step changed other than one phase");

	a_quad_idle : assert property (@(posedge ref_clk) disable iff (rst) // RQ13
		!step |=> $stable({phase_a_q, phase_b_q}))
		else $error("quadrature moved without a step");

endmodule : sfb_quad_gen

//--- rtl/sfb_res_lut.sv
/*
 Guideline resonance frequency per tune level, in 0.1 Hz units.
 Assumes level is held in 1..32 by the register logic.
*/
`timescale 1ns/1ps

module sfb_res_lut
	import sfb_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  level_m1,
	output logic      [11:0] freq_q
);

	logic [11:0] freq_d;

	// ----------------------------------------
	// Table
	// ----------------------------------------
	// RQ3: monotonic 10.0 to 400.0 Hz
	always_comb
	begin
		case (level_m1)
			5'h00: freq_d = 12'h064;
			5'h01: freq_d = 12'h071;
			5'h02: freq_d = 12'h07F;
			5'h03: freq_d = 12'h08F;
			5'h04: freq_d = 12'h0A1;
			5'h05: freq_d = 12'h0B5;
			5'h06: freq_d = 12'h0CC;
			5'h07: freq_d = 12'h0E6;
			5'h08: freq_d = 12'h103;
			5'h09: freq_d = 12'h124;
			5'h0A: freq_d = 12'h149;
			5'h0B: freq_d = 12'h172;
			5'h0C: freq_d = 12'h1A1;
			5'h0D: freq_d = 12'h1D6;
			5'h0E: freq_d = 12'h211;
			5'h0F: freq_d = 12'h254;
			5'h10: freq_d = 12'h29F;
			5'h11: freq_d = 12'h2F4;
			5'h12: freq_d = 12'h354;
			5'h13: freq_d = 12'h3BF;
			5'h14: freq_d = 12'h438;
			5'h15: freq_d = 12'h4C1;
			5'h16: freq_d = 12'h55B;
			5'h17: freq_d = 12'h608;
			5'h18: freq_d = 12'h6CB;
			5'h19: freq_d = 12'h7A7;
			5'h1A: freq_d = 12'h89E;
			5'h1B: freq_d = 12'h9B5;
			5'h1C: freq_d = 12'hAEF;
			5'h1D: freq_d = 12'hC51;
			5'h1E: freq_d = 12'hDDF;
			default: freq_d = 12'hFA0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		// Reset value is the entry of the reset tune level, never out of range
		if (rst)
			freq_q <= 12'h172;
		else
			freq_q <= freq_d;
	end

	a_lut_bounds : assert property (@(posedge ref_clk) disable iff (rst) // RQ3
		##1 (freq_q >= 12'h064 && freq_q <= 12'hFA0))
		else $error("resonance guideline out of range");

endmodule : sfb_res_lut

//--- dv/sfb_enc_model.sv
/*
 Motor encoder model: drives count and direction pins of the block.
 Assumes the bench calls spin() from one process at a time.
*/
`timescale 1ns/1ps

module sfb_enc_model
(
	input  wire logic ref_clk,
	output logic      enc_step_pin,
	output logic      enc_ccw_pin
);
	initial
	begin
		enc_step_pin = 1'b0;
		enc_ccw_pin  = 1'b0;
	end

	// ----------------------------------------
	// Count bursts
	// ----------------------------------------
	// rate far under limit
	// Pin stays low between bursts, so no stray count is seen
	task automatic spin(input int counts, input logic counter_clockwise, input int half);
		enc_ccw_pin <= counter_clockwise;
		repeat (counts)
		begin
			repeat (half) @(posedge ref_clk);
			enc_step_pin <= 1'b1;
			repeat (half) @(posedge ref_clk);
			enc_step_pin <= 1'b0;
		end
		repeat (10) @(posedge ref_clk);
	endtask : spin
endmodule : sfb_enc_model

//--- dv/sfb_settings_tb_top.sv
/*
 Self-checking bench for the servo feedback settings block.
 Assumes rtl/ and dv/sfb_enc_model.sv are compiled first, rtl/ on the include path.
*/
`timescale 1ns/1ps
`include "sfb_params.svh"

module sfb_settings_tb_top
	import sfb_pkg::*;
;
	logic        ref_clk;
	logic        rst;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] pos_error;
	logic        cmd_step;
	logic        cmd_addr_up;
	logic        enc_step_pin;
	logic        enc_ccw_pin;
	logic        in_position_output;
	logic        motor_step_q;
	logic        motor_ccw_q;
	logic [15:0] tune_method_selector;
	logic [4:0]  tune_level_m1_q;
	logic        enc_phase_a;
	logic        enc_phase_b;
	logic        pa_q;
	logic        pb_q;
	logic [31:0] rdata;
	logic [31:0] ew;
	sfb_word_t   w;
	int          mismatches;
	int          num_checks;
	int          seed;
	int          edges;
	int          a_rises;
	int          lvl;
	int          i;
	logic [11:0] res_tab [32] = '{12'h064, 12'h071, 12'h07F, 12'h08F, 12'h0A1, 12'h0B5,
		12'h0CC, 12'h0E6, 12'h103, 12'h124, 12'h149, 12'h172, 12'h1A1, 12'h1D6, 12'h211,
		12'h254, 12'h29F, 12'h2F4, 12'h354, 12'h3BF, 12'h438, 12'h4C1, 12'h55B, 12'h608,
		12'h6CB, 12'h7A7, 12'h89E, 12'h9B5, 12'hAEF, 12'hC51, 12'hDDF, 12'hFA0};

	sfb_settings DUT
	(
		.ref_clk              (ref_clk),
		.rst                  (rst),
		.avs_address          (avs_address),
		.avs_read             (avs_read),
		.avs_write            (avs_write),
		.avs_writedata        (avs_writedata),
		.avs_readdata         (avs_readdata),
		.avs_waitrequest      (avs_waitrequest),
		.pos_error            (pos_error),
		.cmd_step             (cmd_step),
		.cmd_addr_up          (cmd_addr_up),
		.enc_step_pin         (enc_step_pin),
		.enc_ccw_pin          (enc_ccw_pin),
		.in_position_output   (in_position_output),
		.motor_step_q         (motor_step_q),
		.motor_ccw_q          (motor_ccw_q),
		.tune_method_selector (tune_method_selector),
		.tune_level_m1_q      (tune_level_m1_q),
		.enc_phase_a          (enc_phase_a),
		.enc_phase_b          (enc_phase_b)
	);

	sfb_enc_model ENC
	(
		.ref_clk      (ref_clk),
		.enc_step_pin (enc_step_pin),
		.enc_ccw_pin  (enc_ccw_pin)
	);

	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	function automatic logic exp_inpos(input logic [31:0] e, input sfb_word_t win);
		logic [31:0] mag;
		mag = e[31] ? -e : e;
		return mag <= {16'h0000, win};
	endfunction : exp_inpos

	function automatic int exp_edges(input int n, input int setting, input logic div);
		longint prod;
		prod = longint'(n) * setting;
		return div ? n / setting : int'(prod / `SFB_ENC_RES);
	endfunction : exp_edges

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address   <= {idx, 2'b00};
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		// No limit here: a hung slave is caught by the watchdog
		while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		check(n, 2, "bus answer");
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp, input string what);
		bus(1'b0, idx, 32'h0000_0000);
		check(rdata, exp, what);
	endtask : rd_chk

	task automatic cmd(input logic up, input logic exp_ccw);
		@(posedge ref_clk);
		cmd_step    <= 1'b1;
		cmd_addr_up <= up;
		@(posedge ref_clk);
		cmd_step <= 1'b0;
		@(posedge ref_clk);
		check(motor_step_q, 1'b1, "motor step");
		check(motor_ccw_q, exp_ccw, "motor direction");
	endtask : cmd

	task automatic inpos(input logic [31:0] e, input logic spd);
		@(posedge ref_clk);
		pos_error <= e;
		repeat (2) @(posedge ref_clk);
		check(in_position_output, exp_inpos(e, w) & ~spd, "in position");
	endtask : inpos

	task automatic spin_chk(input int n, input logic counter_clockwise, input int setting, input logic div);
		edges   = 0;
		a_rises = 0;
		ENC.spin(n, counter_clockwise, 2 + ($random(seed) & 1));
		check(edges, exp_edges(n, setting, div), "output edges");
		check(a_rises, exp_edges(n, setting, div) / 4, "A pulses");
	endtask : spin_chk

	task automatic do_reset();
		rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
	endtask : do_reset

	// ----------------------------------------
	// Clock, quadrature monitor, watchdog
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			pa_q = 1'b0;
			pb_q = 1'b0;
		end
		else if ({enc_phase_a, enc_phase_b} !== {pa_q, pb_q})
		begin
			edges++;
			if (enc_phase_a && !pa_q)
				a_rises++;
			check({enc_phase_a, enc_phase_b}, enc_ccw_pin ? {~pb_q, pa_q} : {pb_q, ~pa_q}, "gray step");
			pa_q = enc_phase_a;
			pb_q = enc_phase_b;
		end
	end

	// Whole run needs under 10000 cycles; four times that marks a hang
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		mismatches++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 11;
		mismatches = 0;
		num_checks = 0;
		edges = 0;
		a_rises = 0;
		rst = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		pos_error = 32'h0000_0000;
		cmd_step = 1'b0;
		cmd_addr_up = 1'b0;
		do_reset();
		rd_chk(`SFB_OFS_TUNE_METHOD, `SFB_RST_TUNE_METHOD, "method reset");
		check(tune_method_selector, `SFB_RST_TUNE_METHOD, "method port");
		rd_chk(`SFB_OFS_POS_WINDOW, `SFB_RST_POS_WINDOW, "window reset");
		rd_chk(`SFB_OFS_ROT_SENSE, `SFB_RST_ROT_SENSE, "sense reset");
		rd_chk(`SFB_OFS_PULSE_OUT, `SFB_RST_PULSE_OUT, "setting reset");
		rd_chk(`SFB_OFS_OUT_MODE, `SFB_RST_OUT_MODE, "mode reset");
		bus(1'b1, 4'hF, 32'h0000_FFFF);
		rd_chk(4'hF, 32'h0000_0000, "unmapped read");
		ew = {16'h0000, 16'($random(seed))};
		bus(1'b1, `SFB_OFS_TUNE_METHOD, ew);
		rd_chk(`SFB_OFS_TUNE_METHOD, ew, "method readback");
		check(tune_method_selector, ew[15:0], "method port");
		// Levels 0, 33 and upper bits set are refused; 1..32 walk the whole table
		lvl = `SFB_RST_TUNE_LEVEL;
		for (i = 0; i <= 34; i++)
		begin
			ew = (i == 34) ? 32'h0001_0005 : i;
			bus(1'b1, `SFB_OFS_TUNE_LEVEL, ew);
			if (ew >= 1 && ew <= 32)
				lvl = ew;
			rd_chk(`SFB_OFS_TUNE_LEVEL, lvl, "level readback");
			rd_chk(`SFB_OFS_RESONANCE, res_tab[lvl - 1], "resonance");
			check(tune_level_m1_q, lvl - 1, "level port");
		end
		for (i = 0; i < 6; i++)
		begin
			w = (i == 0) ? 16'h0000 : 16'($random(seed));
			ew = {16'h0000, w};
			bus(1'b1, `SFB_OFS_POS_WINDOW, ew);
			rd_chk(`SFB_OFS_POS_WINDOW, ew, "window readback");
			inpos(ew, 1'b0);
			inpos(ew + 1, 1'b0);
			inpos(-ew, 1'b0);
			inpos(-(ew + 1), 1'b0);
		end
		bus(1'b1, `SFB_OFS_CONTROL, 32'h0000_0001);
		inpos(32'h0000_0000, 1'b1);
		bus(1'b1, `SFB_OFS_CONTROL, 32'h0000_0000);
		inpos(32'h0000_0000, 1'b0);
		cmd(1'b1, 1'b1);
		cmd(1'b0, 1'b0);
		bus(1'b1, `SFB_OFS_ROT_SENSE, 32'h0000_0001);
		cmd(1'b1, 1'b1);
		bus(1'b1, `SFB_OFS_CONTROL, 32'h0000_0002);
		rd_chk(`SFB_OFS_STATUS, 32'h0000_0003, "status");
		cmd(1'b1, 1'b0);
		cmd(1'b0, 1'b1);
		bus(1'b1, `SFB_OFS_ROT_SENSE, 32'h0000_0002);
		rd_chk(`SFB_OFS_ROT_SENSE, 32'h0000_0001, "sense refused");
		bus(1'b1, `SFB_OFS_PULSE_OUT, 32'h0000_0008);
		bus(1'b1, `SFB_OFS_OUT_MODE, 32'h0000_0010);
		bus(1'b1, `SFB_OFS_PULSE_OUT, 32'h0000_0000);
		rd_chk(`SFB_OFS_PULSE_OUT, 32'h0000_0008, "zero refused");
		rd_chk(`SFB_OFS_PULSE_ACT, `SFB_RST_PULSE_OUT, "setting deferred");
		bus(1'b1, `SFB_OFS_CONTROL, 32'h0000_0002);
		rd_chk(`SFB_OFS_PULSE_ACT, 32'h0000_0008, "setting applied");
		rd_chk(`SFB_OFS_STATUS, 32'h0000_0007, "status division");
		spin_chk(32, 1'b1, 8, 1'b1);
		spin_chk(32, 1'b0, 8, 1'b1);
		bus(1'b1, `SFB_OFS_OUT_MODE, 32'h0000_0000);
		bus(1'b1, `SFB_OFS_PULSE_OUT, 32'h0000_FFFF);
		bus(1'b1, `SFB_OFS_CONTROL, 32'h0000_0002);
		spin_chk(544, 1'b1, 65535, 1'b0);
		do_reset();
		rd_chk(`SFB_OFS_ROT_SENSE, `SFB_RST_ROT_SENSE, "sense after reset");
		rd_chk(`SFB_OFS_PULSE_ACT, `SFB_RST_PULSE_OUT, "active after reset");
		cmd(1'b1, 1'b1);
		wrap_up();
	end
endmodule : sfb_settings_tb_top
